// file: rsse_pkg.sv
// constants, opcodes and types shared by the rotate/subtract/sleep block
package rsse_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] OFS_CMD   = 8'h00;
  localparam logic [7:0] OFS_WREG  = 8'h04;
  localparam logic [7:0] OFS_STAT  = 8'h08;
  localparam logic [7:0] OFS_FADDR = 8'h0C;
  localparam logic [7:0] OFS_FDATA = 8'h10;
  localparam logic [7:0] OFS_WAKE  = 8'h14;
  // command register fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_DEST_BIT = 3;
  localparam int CMD_ADDR_LSB = 4;
  localparam int CMD_LIT_LSB  = 16;
  localparam int CMD_BUSY_BIT = 31;
  // status register fields
  localparam int ST_C     = 0;
  localparam int ST_DC    = 1;
  localparam int ST_Z     = 2;
  localparam int ST_DOWN  = 3;
  localparam int ST_TO    = 4;
  localparam int ST_SLEEP = 5;
  // values after reset, and axi response codes
  localparam logic       RST_DOWN  = 1'b1;
  localparam logic       RST_TO    = 1'b1;
  localparam logic [7:0] RST_WREG  = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLV  = 2'h2;
  // file register space, addresses 0 to 127
  localparam int FILE_DEPTH = 128;
  // opcodes carried in the command register
  typedef enum logic [2:0] {
    OP_NOP  = 3'h0,
    OP_RLC  = 3'h1,
    OP_RRC  = 3'h2,
    OP_SUBL = 3'h3,
    OP_SLP  = 3'h4,
    OP_RET  = 3'h5
  } rsse_op_t;
  // execution sequencer, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_EXEC  = 3'h2,
    ST_EXEC2 = 3'h4
  } rsse_state_t;
endpackage

// file: rsse_alu_if.sv
// operand and result bundle between the sequencer and the arithmetic unit
`timescale 1ns/10ps
interface rsse_alu_if;
  import rsse_pkg::*;
  rsse_op_t   op;        // operation in flight
  logic [7:0] operand;   // addressed file register
  logic [7:0] wIn;       // working register
  logic [7:0] literal;   // 8-bit literal
  logic       carryIn;   // current carry flag
  logic [7:0] result;    // computed value
  logic       carryOut;  // new carry
  logic       dcOut;     // new digit carry
  logic       zOut;      // new zero flag
  logic       arithOp;   // dc and z are updated
  modport seq (output op, operand, wIn, literal, carryIn,
               input result, carryOut, dcOut, zOut, arithOp);
  modport alu (input op, operand, wIn, literal, carryIn,
               output result, carryOut, dcOut, zOut, arithOp);
endinterface

// file: rsse_alu.sv
// combinational rotate-through-carry and subtract-from-literal unit
`timescale 1ns/10ps
module rsse_alu
  import rsse_pkg::*;
(
  // operands in, results out
  rsse_alu_if.alu aluIf
);
  logic [8:0] diff;  // literal minus working register, borrow in bit 8

  // result and flag computation per operation
  always_comb begin
    diff            = {1'b0, aluIf.literal} - {1'b0, aluIf.wIn};
    aluIf.result    = aluIf.operand;
    aluIf.carryOut  = aluIf.carryIn;
    aluIf.dcOut     = 1'b0;
    aluIf.zOut      = 1'b0;
    aluIf.arithOp   = 1'b0;
    unique case (aluIf.op)
      OP_RLC: begin
        // old carry into bit 0, old bit 7 out
        aluIf.result   = {aluIf.operand[6:0], aluIf.carryIn};
        aluIf.carryOut = aluIf.operand[7];
      end
      OP_RRC: begin
        // old carry into bit 7, old bit 0 out
        aluIf.result   = {aluIf.carryIn, aluIf.operand[7:1]};
        aluIf.carryOut = aluIf.operand[0];
      end
      OP_SUBL: begin
        // two's complement k - w
        aluIf.result   = diff[7:0];
        aluIf.carryOut = (aluIf.wIn <= aluIf.literal);
        aluIf.dcOut    = (aluIf.wIn[3:0] <= aluIf.literal[3:0]);
        aluIf.zOut     = (diff[7:0] == 8'h00);
        aluIf.arithOp  = 1'b1;
      end
      default: begin
        // other operations pass the operand untouched
        aluIf.result = aluIf.operand;
      end
    endcase
  end
endmodule

// file: rsse_core.sv
// execution core for rotate, subtract-from-literal and sleep, axi4-lite regs
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Operation
// - rotate left through carry, file 0..127
// - dest bit: 0 to working, 1 to file
// - rotate right through carry, same destination
// - sleep clears the power-down flag
// - sleep sets the time-out flag
// - sleep clears watchdog counter and prescaler
// - sleep enters low power, stops oscillator
// - subtract: literal minus working register
// - subtract to working; carry, digit carry rules
// - one cycle per instruction, returns take two
module rsse_core
  import rsse_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // watchdog and oscillator links
  output logic             watchdogClear,
  output logic             prescalerClear,
  output logic             oscStopReq,
  output logic             sleepState
);
  // register decode, used for both read and write paths
  function automatic logic [2:0] regIndex(input logic [7:0] a);
    unique case (a)
      OFS_CMD:   regIndex = 3'h0;
      OFS_WREG:  regIndex = 3'h1;
      OFS_STAT:  regIndex = 3'h2;
      OFS_FADDR: regIndex = 3'h3;
      OFS_FDATA: regIndex = 3'h4;
      OFS_WAKE:  regIndex = 3'h5;
      default:   regIndex = 3'h7;
    endcase
  endfunction

  // byte-lane merge for partial writes
  function automatic logic [31:0] laneMerge(input logic [31:0] o,
                                            input logic [31:0] n,
                                            input logic [3:0]  s);
    for (int i = 0; i < 4; i++) begin
      laneMerge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  rsse_alu_if aluIf ();            // link to the arithmetic unit
  rsse_alu    uAlu (.aluIf(aluIf));

  logic [7:0]  fileMem [FILE_DEPTH]; // file registers, no reset
  rsse_state_t state_q, state_d;     // execution sequencer
  rsse_op_t    cmdOp_q, cmdOp_d;     // latched opcode
  logic        cmdDest_q, cmdDest_d; // destination select
  logic [6:0]  cmdAddr_q, cmdAddr_d; // file address
  logic [7:0]  cmdLit_q, cmdLit_d;   // literal
  logic [7:0]  wReg_q, wReg_d;       // working register
  logic        cFlag_q, cFlag_d;     // carry
  logic        dcFlag_q, dcFlag_d;   // digit carry
  logic        zFlag_q, zFlag_d;     // zero
  logic        downFlag_q, downFlag_d; // power-down, low after sleep
  logic        toFlag_q, toFlag_d;   // time-out
  logic        sleep_q, sleep_d;     // low-power state
  logic        wdClr_q, wdClr_d;     // watchdog clear pulse
  logic [6:0]  fAddr_q, fAddr_d;     // software file pointer
  logic        fileWe;               // file write strobe
  logic [6:0]  fileWa;               // file write address
  logic [7:0]  fileWd;               // file write data
  // bus state
  logic        awReady_q, awReady_d, wReady_q, wReady_d;
  logic        awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [7:0]  awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0]  wStrb_q, wStrb_d;
  logic        bValid_q, bValid_d, rValid_q, rValid_d, arReady_q, arReady_d;
  logic [1:0]  bResp_q, bResp_d, rResp_q, rResp_d;
  logic [31:0] rData_q, rData_d;
  logic        awTake, wTake, doWrite, arTake;
  logic [2:0]  wIdx;
  logic [7:0]  wAddrNow;
  logic [31:0] wDataNow, wMerged, rWord;
  logic [3:0]  wStrbNow;

  // operand feed into the arithmetic unit
  always_comb begin
    aluIf.op      = cmdOp_q;
    aluIf.operand = fileMem[cmdAddr_q];
    aluIf.wIn     = wReg_q;
    aluIf.literal = cmdLit_q;
    aluIf.carryIn = cFlag_q;
  end

  // read data mux
  always_comb begin
    rWord = 32'h0000_0000;
    unique case (regIndex(s_axi_araddr))
      3'h0: begin
        rWord[CMD_OP_LSB +: 3]   = cmdOp_q;
        rWord[CMD_DEST_BIT]      = cmdDest_q;
        rWord[CMD_ADDR_LSB +: 7] = cmdAddr_q;
        rWord[CMD_LIT_LSB +: 8]  = cmdLit_q;
        rWord[CMD_BUSY_BIT]      = (state_q != ST_IDLE);
      end
      3'h1: rWord[7:0] = wReg_q;
      3'h2: begin
        rWord[ST_C]     = cFlag_q;
        rWord[ST_DC]    = dcFlag_q;
        rWord[ST_Z]     = zFlag_q;
        rWord[ST_DOWN]  = downFlag_q;
        rWord[ST_TO]    = toFlag_q;
        rWord[ST_SLEEP] = sleep_q;
      end
      3'h3: rWord[6:0] = fAddr_q;
      3'h4: rWord[7:0] = fileMem[fAddr_q];
      default: rWord = 32'h0000_0000;
    endcase
  end

  // bus handshakes: address and data taken in either order
  always_comb begin
    awTake   = s_axi_awvalid && awReady_q;
    wTake    = s_axi_wvalid && wReady_q;
    arTake   = s_axi_arvalid && arReady_q;
    wAddrNow = awTake ? s_axi_awaddr : awAddr_q;
    wDataNow = wTake ? s_axi_wdata : wData_q;
    wStrbNow = wTake ? s_axi_wstrb : wStrb_q;
    wIdx     = regIndex(wAddrNow);
    wMerged  = laneMerge(32'h0000_0000, wDataNow, wStrbNow);
    doWrite  = (awHeld_q || awTake) && (wHeld_q || wTake) && !bValid_q;
    awAddr_d = awTake ? s_axi_awaddr : awAddr_q;
    wData_d  = wTake ? s_axi_wdata : wData_q;
    wStrb_d  = wTake ? s_axi_wstrb : wStrb_q;
    awHeld_d = (awHeld_q || awTake) && !doWrite;
    wHeld_d  = (wHeld_q || wTake) && !doWrite;
    bValid_d = doWrite || (bValid_q && !s_axi_bready);
    bResp_d  = bResp_q;
    if (doWrite) begin
      // unmapped offsets answer with a slave error
      bResp_d = (wIdx == 3'h7) ? RESP_SLV : RESP_OKAY;
    end
    awReady_d = !awHeld_d && !bValid_d;
    wReady_d  = !wHeld_d && !bValid_d;
    rValid_d  = arTake || (rValid_q && !s_axi_rready);
    rData_d   = arTake ? rWord : rData_q;
    rResp_d   = rResp_q;
    if (arTake) begin
      rResp_d = (regIndex(s_axi_araddr) == 3'h7) ? RESP_SLV : RESP_OKAY;
    end
    arReady_d = !rValid_d;
  end

  // bus registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      awReady_q <= 1'b0;
      wReady_q  <= 1'b0;
      awHeld_q  <= 1'b0;
      wHeld_q   <= 1'b0;
      awAddr_q  <= 8'h00;
      wData_q   <= 32'h0000_0000;
      wStrb_q   <= 4'h0;
      bValid_q  <= 1'b0;
      bResp_q   <= RESP_OKAY;
      arReady_q <= 1'b0;
      rValid_q  <= 1'b0;
      rData_q   <= 32'h0000_0000;
      rResp_q   <= RESP_OKAY;
    end else begin
      awReady_q <= awReady_d;
      wReady_q  <= wReady_d;
      awHeld_q  <= awHeld_d;
      wHeld_q   <= wHeld_d;
      awAddr_q  <= awAddr_d;
      wData_q   <= wData_d;
      wStrb_q   <= wStrb_d;
      bValid_q  <= bValid_d;
      bResp_q   <= bResp_d;
      arReady_q <= arReady_d;
      rValid_q  <= rValid_d;
      rData_q   <= rData_d;
      rResp_q   <= rResp_d;
    end
  end

  // sequencer and architectural state; execution outranks software writes
  always_comb begin
    state_d   = state_q;
    cmdOp_d   = cmdOp_q;
    cmdDest_d = cmdDest_q;
    cmdAddr_d = cmdAddr_q;
    cmdLit_d  = cmdLit_q;
    wReg_d    = wReg_q;
    cFlag_d   = cFlag_q;
    dcFlag_d  = dcFlag_q;
    zFlag_d   = zFlag_q;
    downFlag_d = downFlag_q;
    toFlag_d  = toFlag_q;
    sleep_d   = sleep_q;
    wdClr_d   = 1'b0;
    fAddr_d   = fAddr_q;
    fileWe    = 1'b0;
    fileWa    = fAddr_q;
    fileWd    = wMerged[7:0];
    // software side of the register file
    if (doWrite) begin
      unique case (wIdx)
        3'h0: begin
          // commands are dropped while busy or asleep
          if (state_q == ST_IDLE && !sleep_q && wStrbNow[0]) begin
            cmdOp_d   = rsse_op_t'(wMerged[CMD_OP_LSB +: 3]);
            cmdDest_d = wMerged[CMD_DEST_BIT];
            cmdAddr_d = wMerged[CMD_ADDR_LSB +: 7];
            cmdLit_d  = wMerged[CMD_LIT_LSB +: 8];
            state_d   = ST_EXEC;
          end
        end
        3'h1: if (wStrbNow[0]) wReg_d = wMerged[7:0];
        3'h2: if (wStrbNow[0]) begin
          // power-down and time-out are read-only to software
          cFlag_d  = wMerged[ST_C];
          dcFlag_d = wMerged[ST_DC];
          zFlag_d  = wMerged[ST_Z];
        end
        3'h3: if (wStrbNow[0]) fAddr_d = wMerged[6:0];
        3'h4: fileWe = wStrbNow[0];
        3'h5: sleep_d = 1'b0;   // wake: resume and restart oscillator
        default: fileWe = 1'b0;
      endcase
    end
    // one instruction cycle per command, two for return
    unique case (state_q)
      ST_IDLE: begin
      end
      ST_EXEC: begin
        state_d = (cmdOp_q == OP_RET) ? ST_EXEC2 : ST_IDLE;
        unique case (cmdOp_q)
          OP_RLC, OP_RRC: begin
            // z and dc untouched by rotates
            cFlag_d = aluIf.carryOut;
            if (cmdDest_q) begin
              fileWe = 1'b1;
              fileWa = cmdAddr_q;
              fileWd = aluIf.result;
            end else begin
              wReg_d = aluIf.result;
            end
          end
          OP_SUBL: begin
            wReg_d   = aluIf.result;
            cFlag_d  = aluIf.carryOut;
            dcFlag_d = aluIf.dcOut;
            zFlag_d  = aluIf.zOut;
          end
          OP_SLP: begin
            downFlag_d = 1'b0;
            toFlag_d = 1'b1;
            wdClr_d  = 1'b1;
            sleep_d  = 1'b1;
          end
          default: begin
            // nop, return and spare codes change no state
            wdClr_d = 1'b0;
          end
        endcase
      end
      ST_EXEC2: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // architectural registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q   <= ST_IDLE;
      cmdOp_q   <= OP_NOP;
      cmdDest_q <= 1'b0;
      cmdAddr_q <= 7'h00;
      cmdLit_q  <= 8'h00;
      wReg_q    <= RST_WREG;
      cFlag_q   <= 1'b0;
      dcFlag_q  <= 1'b0;
      zFlag_q   <= 1'b0;
      downFlag_q <= RST_DOWN;
      toFlag_q  <= RST_TO;
      sleep_q   <= 1'b0;
      wdClr_q   <= 1'b0;
      fAddr_q   <= 7'h00;
    end else begin
      state_q   <= state_d;
      cmdOp_q   <= cmdOp_d;
      cmdDest_q <= cmdDest_d;
      cmdAddr_q <= cmdAddr_d;
      cmdLit_q  <= cmdLit_d;
      wReg_q    <= wReg_d;
      cFlag_q   <= cFlag_d;
      dcFlag_q  <= dcFlag_d;
      zFlag_q   <= zFlag_d;
      downFlag_q <= downFlag_d;
      toFlag_q  <= toFlag_d;
      sleep_q   <= sleep_d;
      wdClr_q   <= wdClr_d;
      fAddr_q   <= fAddr_d;
    end
  end

  // file registers; no reset so it maps to plain storage
  always_ff @(posedge sys_clk) begin
    if (fileWe) fileMem[fileWa] <= fileWd;
  end

  // outputs straight from flip-flops
  assign s_axi_awready  = awReady_q;
  assign s_axi_wready   = wReady_q;
  assign s_axi_bvalid   = bValid_q;
  assign s_axi_bresp    = bResp_q;
  assign s_axi_arready  = arReady_q;
  assign s_axi_rvalid   = rValid_q;
  assign s_axi_rdata    = rData_q;
  assign s_axi_rresp    = rResp_q;
  assign watchdogClear  = wdClr_q;
  assign prescalerClear = wdClr_q;
  assign oscStopReq     = sleep_q;
  assign sleepState     = sleep_q;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic execRot, execSub, execSlp;
  assign execRot = (state_q == ST_EXEC) &&
                   (cmdOp_q == OP_RLC || cmdOp_q == OP_RRC);
  assign execSub = (state_q == ST_EXEC) && (cmdOp_q == OP_SUBL);
  assign execSlp = (state_q == ST_EXEC) && (cmdOp_q == OP_SLP);

  property p_rlc;
    (state_q == ST_EXEC && cmdOp_q == OP_RLC && !cmdDest_q) |=>
      wReg_q == {$past(aluIf.operand[6:0]), $past(cFlag_q)} &&
      cFlag_q == $past(aluIf.operand[7]);
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate left wrong");
  property p_dest;
    (execRot && cmdDest_q && !doWrite) |=> wReg_q == $past(wReg_q) &&
      fileMem[$past(cmdAddr_q)] == $past(aluIf.result);
  endproperty
  a_dest: assert property (p_dest) else $error("dest file wrong");
  property p_rrc;
    (state_q == ST_EXEC && cmdOp_q == OP_RRC && !cmdDest_q) |=>
      wReg_q == {$past(cFlag_q), $past(aluIf.operand[7:1])} &&
      cFlag_q == $past(aluIf.operand[0]);
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate right wrong");
  property p_down;
    execSlp |=> !downFlag_q ##1 !downFlag_q;
  endproperty
  a_down: assert property (p_down) else $error("flag not cleared");
  property p_to;
    execSlp |=> toFlag_q;
  endproperty
  a_to: assert property (p_to) else $error("to not set");
  property p_wdc;
    execSlp |=> watchdogClear && prescalerClear ##1 !watchdogClear;
  endproperty
  a_wdc: assert property (p_wdc) else $error("watchdog clear bad");
  property p_slp;
    execSlp |=> oscStopReq && sleepState && state_q == ST_IDLE;
  endproperty
  a_slp: assert property (p_slp) else $error("sleep not entered");
  property p_sub;
    execSub |=> wReg_q == 8'($past(cmdLit_q) - $past(wReg_q));
  endproperty
  a_sub: assert property (p_sub) else $error("subtract wrong");
  property p_subf;
    execSub |=> cFlag_q == ($past(wReg_q) <= $past(cmdLit_q)) &&
      dcFlag_q == ($past(wReg_q[3:0]) <= $past(cmdLit_q[3:0]));
  endproperty
  a_subf: assert property (p_subf) else $error("sub flags wrong");
  property p_zf;
    (execSub |=> zFlag_q == (wReg_q == 8'h00)) and
    (execRot && !doWrite |=> $stable(zFlag_q) && $stable(dcFlag_q));
  endproperty
  a_zf: assert property (p_zf) else $error("zero flag wrong");
  property p_ret;
    (state_q == ST_EXEC && cmdOp_q == OP_RET) |=>
      state_q == ST_EXEC2 ##1 state_q == ST_IDLE;
  endproperty
  a_ret: assert property (p_ret) else $error("return not two");
  c_rot: cover property (execRot && cmdDest_q);
  c_sub: cover property (execSub ##1 zFlag_q);
  c_slp: cover property (execSlp ##1 sleepState);
  c_ret: cover property (state_q == ST_EXEC2);
endmodule

// file: tb_top.sv
// self-checking bench for the rotate/subtract/sleep core over axi4-lite
`timescale 1ns/10ps
module tb_top
  import rsse_pkg::*;
;
  // clock and reset
  logic        sys_clk = 1'b0;
  logic        reset   = 1'b1;
  // axi4-lite master side
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready  = 1'b0;
  // watchdog and oscillator links
  logic        watchdogClear;
  logic        prescalerClear;
  logic        oscStopReq;
  logic        sleepState;
  // bench bookkeeping
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          wdPulses = 0;
  int          psPulses = 0;
  rsse_core rsse_core_inst (
    .sys_clk(sys_clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .watchdogClear(watchdogClear),
    .prescalerClear(prescalerClear), .oscStopReq(oscStopReq),
    .sleepState(sleepState)
  );
  // 100 mhz clock
  always #5 sys_clk = ~sys_clk;
  // verdict and end of run, reached from the sequence or the timeout
  task automatic test_done();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // cycle ceiling guards against a hung handshake
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors = n_errors + 1;
      test_done();
    end
  end
  // count sleep pulses on the watchdog links
  always @(posedge sys_clk) begin
    if (watchdogClear === 1'b1) wdPulses <= wdPulses + 1;
    if (prescalerClear === 1'b1) psPulses <= psPulses + 1;
  end
  // one comparison, reported at once on mismatch
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // write: both channels offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    @(posedge sys_clk);
    while (s_axi_awvalid || s_axi_wvalid) begin
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      @(posedge sys_clk);
    end
    while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  // read: address held until taken, data taken at the rvalid edge
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    @(posedge sys_clk);
    while (s_axi_arvalid) begin
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      @(posedge sys_clk);
    end
    while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  // issue a command word and poll busy until it clears
  task automatic run_cmd(input logic [31:0] c);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    axw(OFS_CMD, c, r);
    n = 0;
    do begin
      axr(OFS_CMD, d, r);
      n = n + 1;
    end while (d[CMD_BUSY_BIT] !== 1'b0 && n < 20);
    chk("busy clears", {31'h0, d[CMD_BUSY_BIT]}, 32'h0);
  endtask
  // main sequence with a behavioural model of w, flags and file
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int op, fa, fv, w, k, c, dc, z, dst, res, cn, fexp, stat;
    void'($urandom(44481));
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    axr(OFS_WREG, d, r);
    chk("w reset", d, {24'h0, RST_WREG});
    axr(OFS_STAT, d, r);
    chk("stat reset", d, 32'h18);
    for (int i = 0; i < 48; i++) begin
      op = $urandom_range(0, 7);
      // first passes pin right rotate, equal subtract, left rotate
      if (op == 4 || i < 3) op = 1 + ((i + 1) % 3);
      fa = (i == 0) ? 127 : $urandom_range(0, 127);
      fv = $urandom_range(0, 255);
      w = $urandom_range(0, 255);
      k = (i == 1) ? w : $urandom_range(0, 255);
      c = $urandom_range(0, 1);
      dc = $urandom_range(0, 1);
      z = $urandom_range(0, 1);
      dst = $urandom_range(0, 1);
      axw(OFS_FADDR, fa, r);
      axw(OFS_FDATA, fv, r);
      axw(OFS_WREG, w, r);
      axw(OFS_STAT, (z << 2) | (dc << 1) | c, r);
      run_cmd((k << CMD_LIT_LSB) | (fa << CMD_ADDR_LSB) |
              (dst << CMD_DEST_BIT) | op);
      fexp = fv;
      if (op == 1 || op == 2) begin
        res = (op == 1) ? (((fv << 1) & 8'hFF) | c) : ((c << 7) | (fv >> 1));
        cn = (op == 1) ? (fv >> 7) : (fv & 1);
        c = cn;
        if (dst == 1) fexp = res;
        else w = res;
      end else if (op == 3) begin
        res = (k - w) & 8'hFF;
        c = (w <= k);
        dc = ((w & 4'hF) <= (k & 4'hF));
        z = (res == 0);
        w = res;
      end
      axr(OFS_WREG, d, r);
      chk("w result", d, w);
      axr(OFS_FDATA, d, r);
      chk("file result", d, fexp);
      axr(OFS_STAT, d, r);
      stat = 32'h18 | (z << 2) | (dc << 1) | c;
      chk("status flags", d, stat);
    end
    // sleep, then a command while asleep, then wake
    stat = 32'h10 | 32'h20 | (z << 2) | (dc << 1) | c;
    axw(OFS_CMD, OP_SLP, r);
    chk("bresp okay", r, RESP_OKAY);
    repeat (4) @(posedge sys_clk);
    chk("osc stop", {31'h0, oscStopReq}, 32'h1);
    chk("sleep state", {31'h0, sleepState}, 32'h1);
    chk("wd pulses", wdPulses, 1);
    chk("ps pulses", psPulses, 1);
    axr(OFS_STAT, d, r);
    chk("rresp okay", r, RESP_OKAY);
    chk("stat asleep", d, stat);
    axw(OFS_CMD, OP_RLC, r);
    repeat (3) @(posedge sys_clk);
    axr(OFS_WREG, d, r);
    chk("w while asleep", d, w);
    axw(OFS_WAKE, 32'h1, r);
    @(posedge sys_clk);
    chk("woken", {30'h0, oscStopReq, sleepState}, 32'h0);
    axr(OFS_STAT, d, r);
    chk("stat woken", d, stat & 32'h1F);
    // unmapped address on both channels
    axw(8'h40, 32'hFF, r);
    chk("bresp unmapped", r, RESP_SLV);
    axr(8'h40, d, r);
    chk("rresp unmapped", r, RESP_SLV);
    chk("rdata unmapped", d, 32'h0);
    axr(OFS_WAKE, d, r);
    chk("wake reads 0", d, 32'h0);
    // second reset restores the power-down flag
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    axr(OFS_STAT, d, r);
    chk("stat second reset", d, 32'h18);
    test_done();
  end
endmodule
